/* File: design/rpc_pkg.sv */
// constants for the reset and low-power controller
// assumes a 50 MHz system clock and a 32-bit AHB-Lite register bus
`default_nettype none

package rpc_pkg;

    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_OPT = 8'h00;
    localparam logic [7:0] ADDR_PWR = 8'h04;
    localparam logic [7:0] ADDR_SMR = 8'h08;
    localparam logic [7:0] ADDR_DBG = 8'h0c;
    localparam logic [7:0] ADDR_STAT = 8'h10;

    // ----------------------------------------
    // option register fields
    // ----------------------------------------
    localparam int OPT_W = 7;
    localparam int OPT_WATCHDOG_RESET_SELECT_OPTION = 0;
    localparam int OPT_XTAL = 1;
    localparam int OPT_BO_STOP = 2;
    localparam int OPT_EXT_RST = 3;
    localparam int OPT_WDT_OSC = 4;
    localparam int OPT_WDT_EN = 5;
    localparam int OPT_BO_EN = 6;
    localparam logic [OPT_W-1:0] OPT_RST = 7'h78;

    // ----------------------------------------
    // power and status fields
    // ----------------------------------------
    localparam int PWR_LPAMP = 31;
    localparam int DBG_RST_BIT = 0;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_CAUSE_LSB = 4;
    localparam int ST_LVD = 12;
    localparam int CAUSE_W = 6;
    localparam int C_POR = 0;
    localparam int C_BO = 1;
    localparam int C_WDT = 2;
    localparam int C_EXT = 3;
    localparam int C_DBG = 4;
    localparam int C_SMR = 5;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_MHZ = 50;
    localparam int RST_BASE_NS = 1000;
    localparam int XTAL_EXTRA_NS = 5000;
    localparam int OSC_STAB_NS = 2000;
    localparam int CNT_W = 9;
    localparam logic [CNT_W-1:0] RST_BASE_CYC = CNT_W'((RST_BASE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] XTAL_CYC = CNT_W'((XTAL_EXTRA_NS * CLK_MHZ + 999) / 1000);
    localparam logic [CNT_W-1:0] OSC_STAB_CYC = CNT_W'((OSC_STAB_NS * CLK_MHZ + 999) / 1000);

    // ----------------------------------------
    // modes and states
    // ----------------------------------------
    localparam logic [1:0] MODE_ACTIVE = 2'h0;
    localparam logic [1:0] MODE_HALT = 2'h1;
    localparam logic [1:0] MODE_STOP = 2'h2;
    localparam logic [1:0] MODE_RESET = 2'h3;

    typedef enum logic [2:0] {S_RESET, S_ACTIVE, S_HALT, S_STOP, S_WAKE} state_t;

endpackage

`default_nettype wire

/* File: design/rst_pwr_ctrl.sv */
// reset, stop-recovery and low-power mode controller
// assumes synchronous inputs from core, watchdog, supply monitors and port pins
// Function
// - power-on or brown-out event forces full device reset
// - watchdog time-out resets only when reset-select option is set
// - external reset pin resets only when its alternate function is enabled
// - writing one to debugger control bit zero resets the device
// - in stop, watchdog time-out or enabled pin transition starts recovery; with reset-select set a time-out resets instead
// - brown-out forces reset; low-threshold crossing raises an interrupt
// - stop recovery is handled as a reset type
// - reset lasts longer when crystal oscillator option is enabled
// - stop powers down all but brown-out, amplifier and watchdog
// - stop halts crystal and precision oscillators, releases crystal pins
// - in stop, system clock, cpu and program counter all stop
// - in stop, watchdog oscillator and counter run if enabled
// - brown-out circuit runs in stop only if its option allows
// - in stop, amplifier runs if enabled; other peripherals idle
// - halt instruction stops only the cpu; peripherals stay active
// - in halt, oscillator and clock run, cpu and counter stop
// - halt exits on interrupt, watchdog time-out or any reset
// - each power-control bit gates its peripheral's clock
// - active mode is neither stop nor halt; peripherals may be off
//
// Decided for this implementation: the address map and the AHB-Lite interface to the registers.
`default_nettype none

module rst_pwr_ctrl #(
    parameter int N_PERIPH = 8,
    parameter int N_WAKE = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic por_i,
    input wire logic supply_brownout_detect_i,
    input wire logic lvd_below_thr_i,
    input wire logic watchdog_timeout_i,
    input wire logic ext_reset_pin_i,
    input wire logic stop_instr_i,
    input wire logic halt_instr_i,
    input wire logic irq_pending_i,
    input wire logic [N_WAKE-1:0] wake_pins_i,
    output logic sys_reset_o,
    output logic stop_recovery_o,
    output logic sys_clk_en_o,
    output logic cpu_run_o,
    output logic xtal_osc_en_o,
    output logic ipo_en_o,
    output logic xtal_pins_en_o,
    output logic port_a_gpio_o,
    output logic wdt_osc_en_o,
    output logic wdt_run_o,
    output logic brownout_en_o,
    output logic lpamp_en_o,
    output logic [N_PERIPH-1:0] periph_clk_en_o,
    output logic lvd_irq_o,
    output logic [1:0] mode_o
);

    // ----------------------------------------
    // parameter checks
    // ----------------------------------------
    if (N_PERIPH < 1 || N_PERIPH > 31) begin : g_bad_periph
        $error("N_PERIPH must be 1 to 31");
    end
    if (N_WAKE < 1 || N_WAKE > 32) begin : g_bad_wake
        $error("N_WAKE must be 1 to 32");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        rpc_pkg::state_t st;
        logic [rpc_pkg::CNT_W-1:0] cnt;
        logic [N_WAKE-1:0] pins_prev;
        logic [rpc_pkg::OPT_W-1:0] opt;
        logic [N_PERIPH-1:0] pdn;
        logic lpamp;
        logic [N_WAKE-1:0] smr_en;
        logic [rpc_pkg::CAUSE_W-1:0] cause;
        logic lvd;
        logic smr_pulse;
        logic wr_pend;
        logic [7:0] wr_addr;
        logic [31:0] rdata;
    } regs_t;

    regs_t r;
    regs_t r_nxt;

    // address decode: 0..4 mapped, 7 unmapped
    function automatic logic [2:0] reg_index(input logic [7:0] a);
        case (a)
            rpc_pkg::ADDR_OPT: reg_index = 3'h0;
            rpc_pkg::ADDR_PWR: reg_index = 3'h1;
            rpc_pkg::ADDR_SMR: reg_index = 3'h2;
            rpc_pkg::ADDR_DBG: reg_index = 3'h3;
            rpc_pkg::ADDR_STAT: reg_index = 3'h4;
            default: reg_index = 3'h7;
        endcase
    endfunction

    // mode code seen by software and pins
    function automatic logic [1:0] mode_of(input rpc_pkg::state_t s);
        case (s)
            rpc_pkg::S_RESET: mode_of = rpc_pkg::MODE_RESET;
            rpc_pkg::S_HALT: mode_of = rpc_pkg::MODE_HALT;
            rpc_pkg::S_STOP: mode_of = rpc_pkg::MODE_STOP;
            rpc_pkg::S_WAKE: mode_of = rpc_pkg::MODE_STOP;
            default: mode_of = rpc_pkg::MODE_ACTIVE;
        endcase
    endfunction

    // ----------------------------------------
    // event qualification
    // ----------------------------------------
    logic stopped;
    logic wdt_live;
    logic bo_live;
    logic wdt_to;
    logic dbg_hit;
    logic wake;
    logic [rpc_pkg::CAUSE_W-1:0] src;
    logic [rpc_pkg::CNT_W-1:0] rst_len;

    assign stopped = (r.st == rpc_pkg::S_STOP) || (r.st == rpc_pkg::S_WAKE);
    // watchdog counts only with its own oscillator enabled
    assign wdt_live = r.opt[rpc_pkg::OPT_WDT_EN] & r.opt[rpc_pkg::OPT_WDT_OSC];
    assign wdt_to = watchdog_timeout_i & wdt_live;
    // brown-out monitor may be kept off in stop
    assign bo_live = r.opt[rpc_pkg::OPT_BO_EN]
                     & (!stopped | r.opt[rpc_pkg::OPT_BO_STOP]);
    assign dbg_hit = r.wr_pend && reg_index(r.wr_addr) == 3'h3
                     && hwdata_i[rpc_pkg::DBG_RST_BIT];
    // any change on an enabled wake pin
    assign wake = |((wake_pins_i ^ r.pins_prev) & r.smr_en);

    // reset sources, one bit per cause
    always_comb begin
        src = '0;
        src[rpc_pkg::C_POR] = por_i;
        src[rpc_pkg::C_BO] = supply_brownout_detect_i & bo_live;
        src[rpc_pkg::C_WDT] = wdt_to & r.opt[rpc_pkg::OPT_WATCHDOG_RESET_SELECT_OPTION];
        src[rpc_pkg::C_EXT] = ext_reset_pin_i & r.opt[rpc_pkg::OPT_EXT_RST];
        src[rpc_pkg::C_DBG] = dbg_hit;
    end

    // stretched reset when the crystal needs start-up time
    assign rst_len = r.opt[rpc_pkg::OPT_XTAL]
                     ? rpc_pkg::RST_BASE_CYC + rpc_pkg::XTAL_CYC - 1'b1
                     : rpc_pkg::RST_BASE_CYC - 1'b1;

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        logic [31:0] rd;
        rd = '0;
        r_nxt = r;
        r_nxt.smr_pulse = 1'b0;
        r_nxt.pins_prev = wake_pins_i;
        r_nxt.lvd = lvd_below_thr_i;
        // register writes in the data phase
        if (r.wr_pend) begin
            case (reg_index(r.wr_addr))
                3'h0: r_nxt.opt = hwdata_i[rpc_pkg::OPT_W-1:0];
                3'h1: begin
                    r_nxt.pdn = hwdata_i[N_PERIPH-1:0];
                    r_nxt.lpamp = hwdata_i[rpc_pkg::PWR_LPAMP];
                end
                3'h2: r_nxt.smr_en = hwdata_i[N_WAKE-1:0];
                default: ;
            endcase
        end
        // address phase capture; hsize is not checked, so every access is taken as a word
        if (hready_i) begin
            r_nxt.wr_pend = hsel_i & htrans_i[1] & hwrite_i;
            r_nxt.wr_addr = haddr_i[7:0];
            if (hsel_i & htrans_i[1] & !hwrite_i) begin
                case (reg_index(haddr_i[7:0]))
                    3'h0: rd[rpc_pkg::OPT_W-1:0] = r.opt;
                    3'h1: begin
                        rd[N_PERIPH-1:0] = r.pdn;
                        rd[rpc_pkg::PWR_LPAMP] = r.lpamp;
                    end
                    3'h2: rd[N_WAKE-1:0] = r.smr_en;
                    3'h4: begin
                        rd[rpc_pkg::ST_MODE_LSB +: 2] = mode_of(r.st);
                        rd[rpc_pkg::ST_CAUSE_LSB +: rpc_pkg::CAUSE_W] = r.cause;
                        rd[rpc_pkg::ST_LVD] = r.lvd;
                    end
                    default: rd = '0;
                endcase
                r_nxt.rdata = rd;
            end
        end
        // mode sequencing; any reset source wins
        if (|src) begin
            r_nxt.st = rpc_pkg::S_RESET;
            r_nxt.cnt = rst_len;
            r_nxt.cause = src;
        end else begin
            case (r.st)
                rpc_pkg::S_RESET: begin
                    if (r.cnt == '0) begin
                        r_nxt.st = rpc_pkg::S_ACTIVE;
                    end else begin
                        r_nxt.cnt = r.cnt - 1'b1;
                    end
                end
                rpc_pkg::S_ACTIVE: begin
                    if (stop_instr_i) begin
                        r_nxt.st = rpc_pkg::S_STOP;
                    end else if (halt_instr_i) begin
                        r_nxt.st = rpc_pkg::S_HALT;
                    end
                end
                rpc_pkg::S_HALT: begin
                    if (irq_pending_i | wdt_to) begin
                        r_nxt.st = rpc_pkg::S_ACTIVE;
                    end
                end
                rpc_pkg::S_STOP: begin
                    if (wdt_to | wake) begin
                        r_nxt.st = rpc_pkg::S_WAKE;
                        r_nxt.cnt = r.opt[rpc_pkg::OPT_XTAL]
                                    ? rpc_pkg::OSC_STAB_CYC + rpc_pkg::XTAL_CYC - 1'b1
                                    : rpc_pkg::OSC_STAB_CYC - 1'b1;
                    end
                end
                rpc_pkg::S_WAKE: begin
                    if (r.cnt == '0) begin
                        r_nxt.st = rpc_pkg::S_ACTIVE;
                        r_nxt.smr_pulse = 1'b1;
                        r_nxt.cause = '0;
                        r_nxt.cause[rpc_pkg::C_SMR] = 1'b1;
                    end else begin
                        r_nxt.cnt = r.cnt - 1'b1;
                    end
                end
                default: r_nxt.st = rpc_pkg::S_RESET;
            endcase
        end
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            r <= '{st: rpc_pkg::S_RESET, cnt: rpc_pkg::RST_BASE_CYC - 1'b1,
                   pins_prev: '0, opt: rpc_pkg::OPT_RST, pdn: '0, lpamp: 1'b0,
                   smr_en: '0, cause: rpc_pkg::CAUSE_W'(1), lvd: 1'b0,
                   smr_pulse: 1'b0, wr_pend: 1'b0, wr_addr: '0, rdata: '0};
        end else begin
            r <= r_nxt;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = r.rdata;
    assign sys_reset_o = (r.st == rpc_pkg::S_RESET);
    assign stop_recovery_o = r.smr_pulse;
    assign mode_o = mode_of(r.st);
    // clock stops in stop and while oscillators settle
    assign sys_clk_en_o = !stopped;
    assign cpu_run_o = (r.st == rpc_pkg::S_ACTIVE);
    // oscillators and crystal pins
    assign xtal_osc_en_o = r.opt[rpc_pkg::OPT_XTAL] & (r.st != rpc_pkg::S_STOP);
    assign ipo_en_o = (r.st != rpc_pkg::S_STOP);
    assign xtal_pins_en_o = xtal_osc_en_o;
    assign port_a_gpio_o = !xtal_osc_en_o;
    // always-on blocks, each with its own enable
    assign wdt_osc_en_o = r.opt[rpc_pkg::OPT_WDT_OSC];
    assign wdt_run_o = wdt_live;
    assign brownout_en_o = bo_live;
    assign lpamp_en_o = r.lpamp;
    // per-peripheral gating, all idle in stop
    assign periph_clk_en_o = stopped ? '0 : ~r.pdn;
    assign lvd_irq_o = r.lvd;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    localparam int WAKE_MAX = int'(rpc_pkg::OSC_STAB_CYC) + int'(rpc_pkg::XTAL_CYC) + 1;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // consecutive reset cycles seen at the output
    logic [rpc_pkg::CNT_W:0] rst_run;
    logic opt_xtal_d;
    always_ff @(posedge ref_clk_i) begin
        // a source seen again while in reset reloads the length, so restart the count
        if (rst_i || !sys_reset_o || (|src)) begin
            rst_run <= '0;
        end else begin
            rst_run <= rst_run + 1'b1;
        end
        opt_xtal_d <= r.opt[rpc_pkg::OPT_XTAL];
    end

    sequence s_enter_wake;
        r.st == rpc_pkg::S_STOP ##1 r.st == rpc_pkg::S_WAKE;
    endsequence
    sequence s_recovered;
        ##[1:WAKE_MAX] stop_recovery_o && cpu_run_o;
    endsequence

    por_reset_a: assert property (por_i |=> sys_reset_o && r.cause[rpc_pkg::C_POR])
        else $error("power-on did not reset");
    wdt_select_a: assert property (watchdog_timeout_i && !r.opt[rpc_pkg::OPT_WATCHDOG_RESET_SELECT_OPTION]
        && src == '0 && r.st == rpc_pkg::S_ACTIVE |=> !sys_reset_o)
        else $error("watchdog reset while not selected");
    ext_pin_a: assert property (ext_reset_pin_i && !r.opt[rpc_pkg::OPT_EXT_RST]
        && src == '0 && !sys_reset_o |=> !sys_reset_o)
        else $error("reset pin acted while disabled");
    dbg_reset_a: assert property (dbg_hit |=> sys_reset_o && r.cause[rpc_pkg::C_DBG])
        else $error("debugger reset missed");
    stop_wake_a: assert property (r.st == rpc_pkg::S_STOP && wake && src == '0
        |=> r.st == rpc_pkg::S_WAKE)
        else $error("wake pin did not start recovery");
    reset_len_a: assert property ($fell(sys_reset_o) |-> rst_run == (opt_xtal_d
        ? rpc_pkg::RST_BASE_CYC + rpc_pkg::XTAL_CYC : rpc_pkg::RST_BASE_CYC))
        else $error("reset length wrong");
    stop_gate_a: assert property (r.st == rpc_pkg::S_STOP |-> !sys_clk_en_o && !cpu_run_o
        && periph_clk_en_o == '0 && !ipo_en_o && port_a_gpio_o)
        else $error("stop mode left logic running");
    halt_run_a: assert property (r.st == rpc_pkg::S_HALT |-> sys_clk_en_o && !cpu_run_o
        && periph_clk_en_o == ~r.pdn)
        else $error("halt mode gating wrong");
    halt_exit_a: assert property (r.st == rpc_pkg::S_HALT && irq_pending_i && src == '0
        |=> cpu_run_o)
        else $error("interrupt did not end halt");
    bo_stop_a: assert property (stopped && !r.opt[rpc_pkg::OPT_BO_STOP]
        |-> !brownout_en_o)
        else $error("brown-out live in stop");
    wake_wait_a: assert property (s_enter_wake |-> !cpu_run_o [*8])
        else $error("cpu resumed before oscillators settled");
    wake_done_a: assert property (s_enter_wake ##0 (src == '0) |-> s_recovered
        or ##[1:WAKE_MAX] sys_reset_o)
        else $error("stop recovery never finished");

endmodule

`default_nettype wire

/* File: verification/cpu_model.sv */
// cpu core model that issues stop and halt instruction pulses
// assumes the controller's cpu enable and one bench command per pulse
`default_nettype none

module cpu_model (
    input wire logic ref_clk_i,
    input wire logic cpu_run_i,
    input wire logic go_stop_i,
    input wire logic go_halt_i,
    output logic stop_instr_o,
    output logic halt_instr_o
);
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // instruction issue
    // ----------------------------------------
    // a stopped core executes nothing, so pulses only come while running
    always @(posedge ref_clk_i) begin
        stop_instr_o <= go_stop_i & cpu_run_i;
        halt_instr_o <= go_halt_i & cpu_run_i & !go_stop_i;
    end
endmodule

`default_nettype wire

/* File: verification/reset_and_low_power_control_tb.sv */
// self-checking bench for the reset and low-power controller
// assumes the cpu model beside it and a zero-wait register bus slave
`default_nettype none

module reset_and_low_power_control_tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic clk, rst, hsel, hwrite, hready, hrdy_o, hresp, early;
    logic [1:0] htrans, mode;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, v;
    logic por, bo, lvd, wdt_to, ext_pin, stop_in, halt_in, irq, go_stop, go_halt;
    logic sys_rst, stop_rec, clk_en, cpu_run, xtal_en, ipo_en, xpins, pa_gpio;
    logic wosc, wrun, bo_en, lpamp, lvd_irq;
    logic [7:0] wake, periph, o;
    int failures, cmp_count, seed, n;
    assign hready = hrdy_o;

    rst_pwr_ctrl #(.N_PERIPH(8), .N_WAKE(8)) dut_u (
        .ref_clk_i(clk), .rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hreadyout_o(hrdy_o), .hresp_o(hresp), .hrdata_o(hrdata), .por_i(por),
        .supply_brownout_detect_i(bo), .lvd_below_thr_i(lvd), .watchdog_timeout_i(wdt_to),
        .ext_reset_pin_i(ext_pin), .stop_instr_i(stop_in), .halt_instr_i(halt_in),
        .irq_pending_i(irq), .wake_pins_i(wake), .sys_reset_o(sys_rst),
        .stop_recovery_o(stop_rec), .sys_clk_en_o(clk_en), .cpu_run_o(cpu_run),
        .xtal_osc_en_o(xtal_en), .ipo_en_o(ipo_en), .xtal_pins_en_o(xpins),
        .port_a_gpio_o(pa_gpio), .wdt_osc_en_o(wosc), .wdt_run_o(wrun),
        .brownout_en_o(bo_en), .lpamp_en_o(lpamp), .periph_clk_en_o(periph),
        .lvd_irq_o(lvd_irq), .mode_o(mode));
    cpu_model cpu_u (.ref_clk_i(clk), .cpu_run_i(cpu_run), .go_stop_i(go_stop),
        .go_halt_i(go_halt), .stop_instr_o(stop_in), .halt_instr_o(halt_in));

    // 50 MHz clock
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ----------------------------------------
    // compare, bus and timing tasks
    // ----------------------------------------
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp);
        cmp_count++;
        if (got != exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // status word in active mode with one cause bit
    function automatic logic [31:0] stat_of(input int c);
        return 32'h1 << (rpc_pkg::ST_CAUSE_LSB + c);
    endfunction

    // next edge with hready high, bounded
    task automatic wait_rdy();
        int k;
        k = 0;
        @(posedge clk);
        while (hready !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        if (k >= 50) begin
            failures++;
            final_report();
        end
    endtask

    // one single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        hsel <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk_val(q, exp);
    endtask

    // cycles of device reset, zero if none starts within 4 edges
    task automatic count_reset(output int c);
        int k;
        c = 0;
        k = 0;
        #1;
        while (sys_rst !== 1'b1 && k < 4) begin
            @(posedge clk);
            #1;
            k++;
        end
        while (sys_rst === 1'b1 && c < 1000) begin
            @(posedge clk);
            #1;
            c++;
        end
    endtask

    // one-cycle source pulse, then reset length and cause
    task automatic fire(input int s, input int exp_n, input int cause);
        int c;
        @(posedge clk);
        por <= (s == 0);
        bo <= (s == 1);
        wdt_to <= (s == 2);
        ext_pin <= (s == 3);
        @(posedge clk);
        por <= 1'b0;
        bo <= 1'b0;
        wdt_to <= 1'b0;
        ext_pin <= 1'b0;
        count_reset(c);
        chk_cnt(c, exp_n);
        if (cause >= 0) begin
            rdchk(rpc_pkg::ADDR_STAT, stat_of(cause));
        end
    endtask

    // instruction through the core model, then the mode it leads to
    task automatic go_mode(input logic st, input logic [1:0] m);
        int k;
        @(posedge clk);
        go_stop <= st;
        go_halt <= !st;
        @(posedge clk);
        go_stop <= 1'b0;
        go_halt <= 1'b0;
        k = 0;
        #1;
        while (mode !== m && k < 8) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk_val(32'(mode), 32'(m));
    endtask

    // wake event, then cycles until recovery completes
    task automatic wake_by(input logic [7:0] pins, input logic w, input int exp_n);
        int c;
        @(posedge clk);
        wake <= pins;
        wdt_to <= w;
        @(posedge clk);
        wdt_to <= 1'b0;
        c = 0;
        early = 1'b0;
        #1;
        while (stop_rec !== 1'b1 && c < 1000) begin
            early = early | (cpu_run !== 1'b0) | (clk_en !== 1'b0);
            @(posedge clk);
            #1;
            c++;
        end
        chk_cnt(c, exp_n);
        chk_val({early, cpu_run, clk_en}, 3'b011);
        rdchk(rpc_pkg::ADDR_STAT, stat_of(rpc_pkg::C_SMR));
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {rst, hsel, hwrite, htrans, haddr, hwdata} = {1'b1, 68'h0};
        {por, bo, lvd, wdt_to, ext_pin, irq, go_stop, go_halt, wake} = 16'h0;
        hsize = 3'h2;
        {seed, failures, cmp_count} = {32'd85, 64'd0};
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        count_reset(n);
        chk_cnt(n, int'(rpc_pkg::RST_BASE_CYC));
        chk_val({mode, cpu_run, clk_en}, {rpc_pkg::MODE_ACTIVE, 2'b11});
        chk_val({hrdy_o, hresp}, 2'b10);
        rdchk(rpc_pkg::ADDR_OPT, 32'h78);
        rdchk(rpc_pkg::ADDR_SMR, 32'h0);
        rdchk(8'h14, 32'h0);
        rdchk(rpc_pkg::ADDR_STAT, stat_of(rpc_pkg::C_POR));
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            o = $random(seed);
            wr(rpc_pkg::ADDR_PWR, v);
            wr(rpc_pkg::ADDR_OPT, {25'h0, o[6:0]});
            #1;
            chk_val({periph, lpamp}, {~v[7:0], v[31]});
            chk_val({wosc, wrun, bo_en, xtal_en, pa_gpio},
                    {o[4], o[5] & o[4], o[6], o[1], !o[1]});
            rdchk(rpc_pkg::ADDR_PWR, v & 32'h8000_00ff);
            rdchk(rpc_pkg::ADDR_OPT, {25'h0, o[6:0]});
        end
        wr(rpc_pkg::ADDR_OPT, 32'h78);
        fire(0, int'(rpc_pkg::RST_BASE_CYC), rpc_pkg::C_POR);
        fire(1, int'(rpc_pkg::RST_BASE_CYC), rpc_pkg::C_BO);
        fire(2, 0, -1);
        fire(3, int'(rpc_pkg::RST_BASE_CYC), rpc_pkg::C_EXT);
        @(posedge clk);
        lvd <= 1'b1;
        @(posedge clk);
        #1;
        chk_val(32'(lvd_irq), 32'h1);
        rdchk(rpc_pkg::ADDR_STAT, stat_of(rpc_pkg::C_EXT) | 32'h1000);
        lvd <= 1'b0;
        wr(rpc_pkg::ADDR_OPT, 32'h71);
        fire(3, 0, -1);
        fire(2, int'(rpc_pkg::RST_BASE_CYC), rpc_pkg::C_WDT);
        wr(rpc_pkg::ADDR_OPT, 32'h7a);
        fire(0, int'(rpc_pkg::RST_BASE_CYC + rpc_pkg::XTAL_CYC), rpc_pkg::C_POR);
        wr(rpc_pkg::ADDR_OPT, 32'h78);
        wr(rpc_pkg::ADDR_DBG, 32'h0);
        count_reset(n);
        chk_cnt(n, 0);
        wr(rpc_pkg::ADDR_DBG, 32'h1);
        count_reset(n);
        chk_cnt(n, int'(rpc_pkg::RST_BASE_CYC));
        rdchk(rpc_pkg::ADDR_STAT, stat_of(rpc_pkg::C_DBG));
        // stop with crystal on, amplifier kept, one enabled wake pin
        wr(rpc_pkg::ADDR_OPT, 32'h7a);
        wr(rpc_pkg::ADDR_PWR, 32'h8000_0000);
        wr(rpc_pkg::ADDR_SMR, 32'h1);
        #1;
        chk_val({xtal_en, xpins, pa_gpio}, 3'b110);
        go_mode(1'b1, rpc_pkg::MODE_STOP);
        chk_val({clk_en, cpu_run, ipo_en, xtal_en, xpins, pa_gpio}, 6'b000001);
        chk_val({periph, lpamp, wosc, wrun, bo_en}, 12'h00e);
        fire(1, 0, -1);
        @(posedge clk);
        wake <= 8'h02;
        repeat (5) @(posedge clk);
        #1;
        chk_val(32'(mode), 32'(rpc_pkg::MODE_STOP));
        wake_by(8'h03, 1'b0, int'(rpc_pkg::OSC_STAB_CYC + rpc_pkg::XTAL_CYC));
        wr(rpc_pkg::ADDR_OPT, 32'h78);
        go_mode(1'b1, rpc_pkg::MODE_STOP);
        wake_by(8'h03, 1'b1, int'(rpc_pkg::OSC_STAB_CYC));
        // halt keeps clocks and gated peripherals, leaves on interrupt or timeout
        wr(rpc_pkg::ADDR_PWR, 32'h5);
        for (int i = 0; i < 2; i++) begin
            go_mode(1'b0, rpc_pkg::MODE_HALT);
            chk_val({clk_en, cpu_run, ipo_en, wosc, wrun, periph}, 13'h17fa);
            @(posedge clk);
            irq <= (i == 0);
            wdt_to <= (i == 1);
            @(posedge clk);
            irq <= 1'b0;
            wdt_to <= 1'b0;
            #1;
            chk_val({mode, cpu_run}, {rpc_pkg::MODE_ACTIVE, 1'b1});
        end
        final_report();
    end

    // hang guard
    initial begin
        #2000000;
        failures++;
        final_report();
    end
endmodule

`default_nettype wire
